// file: timer_cc_consts.svh
`ifndef TIMER_CC_CONSTS_SVH
`define TIMER_CC_CONSTS_SVH

// Register byte addresses
`define ADDR_MODE 32'h4004_2650
`define ADDR_CONTROL 32'h4004_2652
`define ADDR_IRQ_ENABLE 32'h4004_2653
`define ADDR_STATUS 32'h4004_2654
`define ADDR_IO_CONTROL 32'h4004_2655
`define ADDR_COUNT 32'h4004_2656
`define ADDR_GR_A 32'h4004_2658
`define ADDR_GR_B 32'h4004_265A
`define ADDR_GR_C 32'h4004_2660
`define ADDR_GR_D 32'h4004_2662

// Reset values
`define RST_GR 16'hFFFF
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000

// Counter limits
`define COUNT_MIN 16'h0000
`define COUNT_MAX 16'hFFFF

// Mode register fields
`define MODE_RUN_BIT 0
`define MODE_PWM_BIT 1
`define MODE_PHASE_BIT 2

// Control register clear source field and codes
`define CTRL_CLR_HI 7
`define CTRL_CLR_LO 6
`define CLR_NONE 2'h0
`define CLR_BY_A 2'h1
`define CLR_BY_B 2'h2

// Status register: direction bit, flags in low nibble
`define STATUS_DIR_BIT 4
`define FLAG_A 0
`define FLAG_B 1
`define FLAG_UDF 2
`define FLAG_OVF 3

// Compare pin actions
`define OUT_KEEP 2'h0
`define OUT_LOW 2'h1
`define OUT_HIGH 2'h2
`define OUT_TOGGLE 2'h3

// Capture edges
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2

`endif

// file: timer_cc_pkg.sv
package timer_cc_pkg;

  typedef struct packed {
    logic buffer_enable;
    logic capture_select;
    logic [1:0] ctrl;
  } chan_ctrl_t;

  // Same bit order as the pin I/O control register
  typedef struct packed {
    chan_ctrl_t b;
    chan_ctrl_t a;
  } io_ctrl_t;

endpackage : timer_cc_pkg

// file: timer_capture_compare_channels.sv
`timescale 1ns/1ps
`include "timer_cc_consts.svh"

// What this block does
// [R01] Compare match drives pin by code: 00 none, 01 low, 10 high, 11 toggle.
// [R02] Capture edge by code: 00 rising, 01 falling, 10 both; 11 prohibited.
// [R03] Mode bit 1 makes channel capture, 0 makes it compare.
// [R04] Before first match pin is high for 01, low for 10 or 11.
// [R05] Buffer bits make C buffer A and D buffer B, else unused.
// [R06] Pin I/O control pin and capture bits apply in timer mode only; its buffer bits also apply in PWM mode.
// [R07] Software writes pin I/O control only while counting is stopped.
// [R08] Counter is accessed only as whole 16-bit transfers, read and write.
// [R09] Counter clears to 0000H on selected channel A or B event.
// [R10] Wrap FFFFH to 0000H sets the overflow flag.
// [R11] Wrap 0000H to FFFFH sets the underflow flag.
// [R12] Counter counts both ways in phase mode, up otherwise, full range.
// [R13] Compare registers match counter continuously; match sets flag and pin action.
// [R14] Capture edge loads counter into register and sets its flag.
// [R15] Buffered compare copies buffer into compare register on each match.
// [R16] Buffered capture moves old capture value into buffer on capture.
// [R17] Four 16-bit read/write general registers reset to FFFFH.
// [R18] In PWM mode match A drives output high, match B low.
// [R19] Compare value 0000H gives one request at start; others each match.
// [R20] Software sets port bits for timer output or input use.
// [R21] Flags ignore 1 writes; 0 clears only after read as 1.
// [R22] Each flag raises interrupt only while its enable bit is 1.
// [R23] All updates on system clock using synchronised pin levels.
module timer_capture_compare_channels (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_sel,
  input wire logic i_bus_wr,
  input wire logic [31:0] i_bus_addr,
  input wire logic [15:0] i_bus_wdata,
  output logic [15:0] o_bus_rdata,
  input wire logic i_count_tick,
  input wire logic i_count_down,
  input wire logic i_timer_pin_0,
  input wire logic i_timer_pin_1,
  output logic o_timer_pin_0,
  output logic o_timer_pin_0_oe,
  output logic o_timer_pin_1,
  output logic o_timer_pin_1_oe,
  output logic o_irq,
  output logic o_event_a,
  output logic o_event_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [3:0] irq_en;
  timer_cc_pkg::io_ctrl_t io_ctrl;
  logic [15:0] count_value;
  logic [15:0] gr [4];
  logic [3:0] flag;
  logic [3:0] armed;
  logic dir_up;
  logic [15:0] rdata;

  logic bus_rd;
  logic bus_wrt;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_ien;
  logic wr_status;
  logic wr_io;
  logic wr_count;
  logic rd_status;
  logic wr_gr [4];

  logic run;
  logic pwm;
  logic down;
  logic step;
  logic clear_ev;
  logic ovf_ev;
  logic udf_ev;
  logic cap_ev [2];
  logic cmp_ev [2];
  logic chan_ev [2];
  logic pin_lvl [2];
  logic pin_oe [2];
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  assign bus_rd = i_bus_sel & ~i_bus_wr;
  assign bus_wrt = i_bus_sel & i_bus_wr;
  assign wr_mode = bus_wrt & (i_bus_addr == `ADDR_MODE);
  assign wr_ctrl = bus_wrt & (i_bus_addr == `ADDR_CONTROL);
  assign wr_ien = bus_wrt & (i_bus_addr == `ADDR_IRQ_ENABLE);
  assign wr_status = bus_wrt & (i_bus_addr == `ADDR_STATUS);
  // [R07] Relies on stopped counter
  assign wr_io = bus_wrt & (i_bus_addr == `ADDR_IO_CONTROL);
  // [R08] Whole-word counter access
  assign wr_count = bus_wrt & (i_bus_addr == `ADDR_COUNT);
  assign rd_status = bus_rd & (i_bus_addr == `ADDR_STATUS);
  assign wr_gr[0] = bus_wrt & (i_bus_addr == `ADDR_GR_A);
  assign wr_gr[1] = bus_wrt & (i_bus_addr == `ADDR_GR_B);
  assign wr_gr[2] = bus_wrt & (i_bus_addr == `ADDR_GR_C);
  assign wr_gr[3] = bus_wrt & (i_bus_addr == `ADDR_GR_D);

  assign run = mode_reg[`MODE_RUN_BIT];
  assign pwm = mode_reg[`MODE_PWM_BIT];

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_reg <= `RST_BYTE;
      ctrl_reg <= `RST_BYTE;
      irq_en <= 4'h0;
      io_ctrl <= `RST_BYTE;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= i_bus_wdata[7:0];
      if (wr_ctrl)
        ctrl_reg <= i_bus_wdata[7:0];
      if (wr_ien)
        irq_en <= i_bus_wdata[3:0];
      if (wr_io)
        io_ctrl <= i_bus_wdata[7:0];
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata <= 16'h0000;
    else if (bus_rd)
    begin
      case (i_bus_addr)
        `ADDR_MODE: rdata <= {8'h00, mode_reg};
        `ADDR_CONTROL: rdata <= {8'h00, ctrl_reg};
        `ADDR_IRQ_ENABLE: rdata <= {12'h000, irq_en};
        `ADDR_STATUS: rdata <= {11'h000, dir_up, flag};
        `ADDR_IO_CONTROL: rdata <= {8'h00, io_ctrl};
        `ADDR_COUNT: rdata <= count_value;
        `ADDR_GR_A: rdata <= gr[0];
        `ADDR_GR_B: rdata <= gr[1];
        `ADDR_GR_C: rdata <= gr[2];
        `ADDR_GR_D: rdata <= gr[3];
        default: rdata <= 16'h0000;
      endcase
    end
  end

  assign o_bus_rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  // [R12] Down only in phase mode
  assign down = mode_reg[`MODE_PHASE_BIT] & i_count_down;
  assign step = run & i_count_tick;

  // [R09] Clear source select
  assign clear_ev = ((ctrl_reg[`CTRL_CLR_HI:`CTRL_CLR_LO] == `CLR_BY_A) & chan_ev[0])
                  | ((ctrl_reg[`CTRL_CLR_HI:`CTRL_CLR_LO] == `CLR_BY_B) & chan_ev[1]);
  // [R10] Up wrap
  assign ovf_ev = step & ~clear_ev & ~wr_count & ~down & (count_value == `COUNT_MAX);
  // [R11] Down wrap
  assign udf_ev = step & ~clear_ev & ~wr_count & down & (count_value == `COUNT_MIN);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_value <= `RST_COUNT;
      dir_up <= 1'b1;
    end
    else
    begin
      if (wr_count)
        count_value <= i_bus_wdata;
      else if (clear_ev)
        count_value <= `COUNT_MIN;
      else if (step)
        count_value <= down ? count_value - 16'h0001 : count_value + 16'h0001;
      if (step)
        dir_up <= ~down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels A and B

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    timer_cc_pkg::chan_ctrl_t cfg;
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
    logic level_d;
    logic rise;
    logic fall;
    logic edge_hit;
    logic eq;
    logic eq_d;

    assign cfg = (ch == 0) ? io_ctrl.a : io_ctrl.b;

    // [R23] Three-stage sampling, level taken when stages two and three agree
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        sync1 <= 1'b0;
        sync2 <= 1'b0;
        sync3 <= 1'b0;
        level <= 1'b0;
        level_d <= 1'b0;
      end
      else
      begin
        sync1 <= (ch == 0) ? i_timer_pin_0 : i_timer_pin_1;
        sync2 <= sync1;
        sync3 <= sync2;
        if (sync2 == sync3)
          level <= sync3;
        level_d <= level;
      end
    end

    assign rise = level & ~level_d;
    assign fall = ~level & level_d;

    // [R02] Edge select; prohibited code captures nothing
    always_comb
    begin
      case (cfg.ctrl)
        `EDGE_RISE: edge_hit = rise;
        `EDGE_FALL: edge_hit = fall;
        `EDGE_BOTH: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end

    // [R03] Capture when mode bit set
    assign cap_ev[ch] = cfg.capture_select & ~pwm & edge_hit;

    // [R13] Match once on entering equality; [R19] a 0000H value hits at start
    assign eq = run & (count_value == gr[ch]);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
        eq_d <= 1'b0;
      else
        eq_d <= eq;
    end
    assign cmp_ev[ch] = eq & ~eq_d & (pwm | ~cfg.capture_select);
    assign chan_ev[ch] = cap_ev[ch] | cmp_ev[ch];

    // [R17] General and buffer registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        gr[ch] <= `RST_GR;
        gr[ch + 2] <= `RST_GR;
      end
      else
      begin
        if (wr_gr[ch])
          gr[ch] <= i_bus_wdata;
        if (wr_gr[ch + 2])
          gr[ch + 2] <= i_bus_wdata;
        // [R14] Capture load
        if (cap_ev[ch])
        begin
          gr[ch] <= count_value;
          // [R16] Old capture into buffer
          if (cfg.buffer_enable)
            gr[ch + 2] <= gr[ch];
        end
        // [R15] Buffer into compare; [R05] only when enabled
        else if (cmp_ev[ch] & cfg.buffer_enable)
          gr[ch] <= gr[ch + 2];
      end
    end

    // Pin level; hardware match beats a same-cycle config write
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
        pin_lvl[ch] <= 1'b0;
      else if (pwm)
      begin
        // [R18] PWM drives pin 0 only
        if (ch == 0)
        begin
          if (cmp_ev[0])
            pin_lvl[ch] <= 1'b1;
          else if (cmp_ev[1])
            pin_lvl[ch] <= 1'b0;
        end
      end
      // [R01] Compare pin action
      else if (cmp_ev[ch])
      begin
        case (cfg.ctrl)
          `OUT_LOW: pin_lvl[ch] <= 1'b0;
          `OUT_HIGH: pin_lvl[ch] <= 1'b1;
          `OUT_TOGGLE: pin_lvl[ch] <= ~pin_lvl[ch];
          default: pin_lvl[ch] <= pin_lvl[ch];
        endcase
      end
      // [R04] Level before first match
      else if (wr_io)
        pin_lvl[ch] <= ((ch == 0) ? i_bus_wdata[1:0] : i_bus_wdata[5:4]) == `OUT_LOW;
    end

    // [R06] Pin control ignored in PWM mode
    assign pin_oe[ch] = pwm ? (ch == 0) : ~cfg.capture_select;
  end

  assign o_timer_pin_0 = pin_lvl[0];
  assign o_timer_pin_1 = pin_lvl[1];
  assign o_timer_pin_0_oe = pin_oe[0];
  assign o_timer_pin_1_oe = pin_oe[1];
  // [R19] Request per channel event
  assign o_event_a = chan_ev[0];
  assign o_event_b = chan_ev[1];

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  assign flag_set = {ovf_ev, udf_ev, chan_ev[1], chan_ev[0]};
  // [R21] Clear only what was read as 1; a new set wins
  assign flag_clr = {4{wr_status}} & ~i_bus_wdata[3:0] & armed;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag <= 4'h0;
      armed <= 4'h0;
    end
    else
    begin
      flag <= flag_set | (flag & ~flag_clr);
      if (wr_status)
        armed <= 4'h0;
      else if (rd_status)
        armed <= flag;
    end
  end

  // [R22] Per-flag enable
  assign o_irq = |(flag & irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_CAPTURE_LOAD: assert property (cap_ev[0] |=> gr[0] == $past(count_value)) // [R14]
    else $error("capture did not load counter");
  AST_CLEAR: assert property (clear_ev && !wr_count |=> count_value == `COUNT_MIN) // [R09]
    else $error("counter not cleared");
  AST_OVERFLOW: assert property (ovf_ev |=> flag[`FLAG_OVF] && count_value == `COUNT_MIN) // [R10]
    else $error("overflow not flagged");
  AST_UNDERFLOW: assert property (udf_ev |=> flag[`FLAG_UDF] && count_value == `COUNT_MAX) // [R11]
    else $error("underflow not flagged");
  AST_TOGGLE: assert property (cmp_ev[0] && !pwm && io_ctrl.a.ctrl == `OUT_TOGGLE
                               |=> o_timer_pin_0 != $past(o_timer_pin_0)) // [R01]
    else $error("toggle missing");
  AST_INIT_LEVEL: assert property (wr_io && !pwm && !cmp_ev[0] && i_bus_wdata[1:0] == `OUT_LOW
                                   |=> o_timer_pin_0) // [R04]
    else $error("initial level not high");
  AST_BUF_COMPARE: assert property (cmp_ev[1] && io_ctrl.b.buffer_enable && !cap_ev[1]
                                    |=> gr[1] == $past(gr[3])) // [R15]
    else $error("buffer not transferred");
  AST_BUF_CAPTURE: assert property (cap_ev[0] && io_ctrl.a.buffer_enable
                                    |=> gr[2] == $past(gr[0])) // [R16]
    else $error("old capture not buffered");
  AST_PWM_HIGH: assert property (pwm && cmp_ev[0] |=> o_timer_pin_0 ##0 o_timer_pin_0_oe) // [R18]
    else $error("pwm set missing");
  AST_FLAG_KEEP: assert property (flag[`FLAG_A] && !armed[`FLAG_A] && wr_status |=> flag[`FLAG_A]) // [R21]
    else $error("unread flag cleared");
  AST_IRQ: assert property (chan_ev[0] && irq_en[0] && !wr_ien |=> o_irq) // [R22]
    else $error("enabled flag raised no irq");

  COV_CAPTURE_BUFFERED: cover property (cap_ev[0] && io_ctrl.a.buffer_enable);
  COV_OVERFLOW: cover property (ovf_ev);
  COV_PWM_CYCLE: cover property (pwm && cmp_ev[0] ##[1:1000] cmp_ev[1]);

endmodule : timer_capture_compare_channels

// file: pin_drive_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pin_drive_model (
  input wire logic i_level_0,
  input wire logic i_level_1,
  input wire logic i_dev_pin_0,
  input wire logic i_dev_oe_0,
  input wire logic i_dev_pin_1,
  input wire logic i_dev_oe_1,
  output logic o_wire_0,
  output logic o_wire_1
);
  // Output or input use
  // Outside level only while the block releases the pin
  assign o_wire_0 = i_dev_oe_0 ? i_dev_pin_0 : i_level_0;
  assign o_wire_1 = i_dev_oe_1 ? i_dev_pin_1 : i_level_1;
endmodule : pin_drive_model

// file: tb_timer_capture_compare_channels.sv
`timescale 1ns/1ps
`include "timer_cc_consts.svh"
////////////////////////////////////////////////////////////
module tb_timer_capture_compare_channels;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic bwr = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic [15:0] rdata;
  logic tick = 1'b0;
  logic down = 1'b0;
  logic lvl0 = 1'b0;
  logic lvl1 = 1'b0;
  logic p0, p0_oe, p1, p1_oe, w0, w1, irq, ev_a, ev_b;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h3d12391e;
  logic [15:0] v, w, r;
  logic [31:0] ga [4];
  timer_cc_pkg::io_ctrl_t io;

  always #20 clk = ~clk;

  timer_capture_compare_channels DUT (
    .i_clk(clk), .i_rst(rst), .i_bus_sel(sel), .i_bus_wr(bwr),
    .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
    .i_count_tick(tick), .i_count_down(down),
    .i_timer_pin_0(w0), .i_timer_pin_1(w1),
    .o_timer_pin_0(p0), .o_timer_pin_0_oe(p0_oe),
    .o_timer_pin_1(p1), .o_timer_pin_1_oe(p1_oe),
    .o_irq(irq), .o_event_a(ev_a), .o_event_b(ev_b)
  );

  pin_drive_model model (
    .i_level_0(lvl0), .i_level_1(lvl1),
    .i_dev_pin_0(p0), .i_dev_oe_0(p0_oe),
    .i_dev_pin_1(p1), .i_dev_oe_1(p1_oe),
    .o_wire_0(w0), .o_wire_1(w1)
  );

////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One access per call, whole 16-bit transfer
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [15:0] d);
    @(negedge clk);
    sel = 1'b1;
    bwr = wr_en;
    addr = a;
    wdata = d;
    @(negedge clk);
    sel = 1'b0;
    r = rdata;
  endtask : bus

  task automatic rchk(input string name, input logic [31:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(name, exp, r);
  endtask : rchk

  task automatic wait_ev(input logic chan_b);
    int n = 0;
    while ((chan_b ? ev_b : ev_a) !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 300)
      begin
        err_count++;
        $display("MISMATCH event wait expected 1 seen 0");
        final_report();
      end
    end
  endtask : wait_ev

  // Exactly n counted edges
  task automatic ticks(input int n);
    tick = 1'b1;
    repeat (n) @(negedge clk);
    tick = 1'b0;
  endtask : ticks

  // Pin level before the first compare match and after it
  function automatic logic pin_level(input logic [1:0] code, input logic matched);
    logic init;
    init = (code == `OUT_LOW);
    if (!matched)
      return init;
    case (code)
      `OUT_LOW: return 1'b0;
      `OUT_HIGH: return 1'b1;
      `OUT_TOGGLE: return ~init;
      default: return init;
    endcase
  endfunction : pin_level

////////////////////////////////////////////////////////////
  initial
  begin
    ga = '{`ADDR_GR_A, `ADDR_GR_B, `ADDR_GR_C, `ADDR_GR_D};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rchk("count reset", `ADDR_COUNT, `RST_COUNT);
    for (int i = 0; i < 4; i++)
    begin
      rchk("gr reset", ga[i], `RST_GR);
      v = 16'($random(seed));
      bus(1'b1, ga[i], v);
      rchk("gr rw", ga[i], v);
    end
    bus(1'b1, 32'h4004_2664, 16'hFFFF);
    rchk("unmapped", 32'h4004_2664, 16'h0000);
    bus(1'b1, `ADDR_GR_B, 16'h8000);
    // Compare codes, clear by A, irq on A
    bus(1'b1, `ADDR_CONTROL, 16'h0040);
    bus(1'b1, `ADDR_IRQ_ENABLE, 16'h0001);
    for (int c = 0; c < 4; c++)
    begin
      io = '0;
      io.a.ctrl = c[1:0];
      bus(1'b1, `ADDR_IO_CONTROL, {8'h00, io});
      bus(1'b1, `ADDR_GR_A, 16'h0010);
      bus(1'b1, `ADDR_COUNT, 16'h0000);
      chk("pin0 initial", 16'(pin_level(c[1:0], 1'b0)), 16'(p0));
      chk("pin0 oe compare", 16'h0001, 16'(p0_oe));
      tick = 1'b1;
      bus(1'b1, `ADDR_MODE, 16'h0001);
      wait_ev(1'b0);
      tick = 1'b0;
      @(negedge clk);
      chk("pin0 action", 16'(pin_level(c[1:0], 1'b1)), 16'(p0));
      chk("irq", 16'h0001, 16'(irq));
      bus(1'b1, `ADDR_MODE, 16'h0000);
      rchk("count clear", `ADDR_COUNT, 16'h0000);
      bus(1'b0, `ADDR_STATUS, 16'h0000);
      chk("flag a", 16'h0001, r & 16'h000F);
      bus(1'b1, `ADDR_STATUS, 16'h0000);
    end
    chk("irq cleared", 16'h0000, 16'(irq));
    rchk("unbuffered compare", `ADDR_GR_A, 16'h0010);
    // Compare value 0000H: one request right at start
    bus(1'b1, `ADDR_GR_A, 16'h0000);
    bus(1'b1, `ADDR_MODE, 16'h0001);
    chk("start request", 16'h0001, 16'(ev_a));
    @(negedge clk);
    chk("single request", 16'h0000, 16'(ev_a));
    bus(1'b1, `ADDR_MODE, 16'h0000);
    // Buffered compare
    io = '0;
    io.a.buffer_enable = 1'b1;
    bus(1'b1, `ADDR_IO_CONTROL, {8'h00, io});
    bus(1'b1, `ADDR_GR_A, 16'h0008);
    v = 16'($random(seed));
    bus(1'b1, `ADDR_GR_C, v);
    tick = 1'b1;
    bus(1'b1, `ADDR_MODE, 16'h0001);
    wait_ev(1'b0);
    tick = 1'b0;
    bus(1'b1, `ADDR_MODE, 16'h0000);
    rchk("buffered compare", `ADDR_GR_A, v);
    // Overflow and flag clearing handshake
    bus(1'b1, `ADDR_CONTROL, 16'h0000);
    bus(1'b1, `ADDR_GR_A, 16'h8000);
    bus(1'b0, `ADDR_STATUS, 16'h0000);
    bus(1'b1, `ADDR_STATUS, 16'h0000);
    bus(1'b1, `ADDR_COUNT, 16'hFFFE);
    bus(1'b1, `ADDR_MODE, 16'h0001);
    ticks(2);
    bus(1'b1, `ADDR_MODE, 16'h0000);
    rchk("count wrap", `ADDR_COUNT, 16'h0000);
    bus(1'b0, `ADDR_STATUS, 16'h0000);
    chk("ovf flag", 16'h0008, r & 16'h000F);
    bus(1'b1, `ADDR_STATUS, 16'h00FF);
    bus(1'b1, `ADDR_STATUS, 16'h0000);
    bus(1'b0, `ADDR_STATUS, 16'h0000);
    chk("ovf kept", 16'h0008, r & 16'h000F);
    bus(1'b1, `ADDR_STATUS, 16'h0000);
    bus(1'b0, `ADDR_STATUS, 16'h0000);
    chk("ovf cleared", 16'h0000, r & 16'h000F);
    // Underflow in phase count mode
    down = 1'b1;
    bus(1'b1, `ADDR_COUNT, 16'h0001);
    bus(1'b1, `ADDR_MODE, 16'h0005);
    ticks(2);
    bus(1'b0, `ADDR_STATUS, 16'h0000);
    chk("udf flag", 16'h0004, r & 16'h000F);
    bus(1'b1, `ADDR_MODE, 16'h0000);
    down = 1'b0;
    rchk("count down", `ADDR_COUNT, 16'hFFFF);
    // Capture edges with buffer; code 3 must capture nothing
    for (int e = 0; e < 4; e++)
    begin
      io = '0;
      io.a.capture_select = 1'b1;
      io.a.buffer_enable = 1'b1;
      io.a.ctrl = e[1:0];
      lvl0 = (e == 1);
      bus(1'b1, `ADDR_IO_CONTROL, {8'h00, io});
      chk("pin0 oe capture", 16'h0000, 16'(p0_oe));
      repeat (10) @(negedge clk);
      w = 16'($random(seed));
      v = 16'($random(seed));
      bus(1'b1, `ADDR_GR_A, w);
      bus(1'b1, `ADDR_COUNT, v);
      lvl0 = ~lvl0;
      if (e == 3)
      begin
        repeat (20) @(negedge clk);
        rchk("prohibited edge", `ADDR_GR_A, w);
      end
      else
      begin
        wait_ev(1'b0);
        repeat (2) @(negedge clk);
        rchk("capture", `ADDR_GR_A, v);
        rchk("capture buffer", `ADDR_GR_C, w);
      end
    end
    // PWM: A sets, B clears, pin control ignored
    bus(1'b1, `ADDR_GR_A, 16'h0004);
    bus(1'b1, `ADDR_GR_B, 16'h0008);
    // Buffer still enabled on A; same value keeps the set point fixed
    bus(1'b1, `ADDR_GR_C, 16'h0004);
    bus(1'b1, `ADDR_CONTROL, 16'h0080);
    bus(1'b1, `ADDR_COUNT, 16'h0000);
    tick = 1'b1;
    bus(1'b1, `ADDR_MODE, 16'h0003);
    wait_ev(1'b0);
    @(negedge clk);
    chk("pwm high", 16'h0001, 16'(p0));
    wait_ev(1'b1);
    @(negedge clk);
    chk("pwm low", 16'h0000, 16'(p0));
    chk("pwm pin1 oe", 16'h0000, 16'(p1_oe));
    tick = 1'b0;
    bus(1'b1, `ADDR_MODE, 16'h0000);
    // Mid-run reset, then buffered compare on channel B
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rchk("gr reset again", `ADDR_GR_B, `RST_GR);
    chk("pin0 oe after reset", 16'h0001, 16'(p0_oe));
    io = '0;
    io.b.ctrl = `OUT_HIGH;
    io.b.buffer_enable = 1'b1;
    bus(1'b1, `ADDR_IO_CONTROL, {8'h00, io});
    chk("pin1 initial", 16'(pin_level(`OUT_HIGH, 1'b0)), 16'(p1));
    v = 16'($random(seed));
    bus(1'b1, `ADDR_GR_D, v);
    bus(1'b1, `ADDR_GR_B, 16'h0002);
    tick = 1'b1;
    bus(1'b1, `ADDR_MODE, 16'h0001);
    wait_ev(1'b1);
    tick = 1'b0;
    @(negedge clk);
    chk("pin1 action", 16'(pin_level(`OUT_HIGH, 1'b1)), 16'(p1));
    bus(1'b1, `ADDR_MODE, 16'h0000);
    rchk("buffered compare b", `ADDR_GR_B, v);
    final_report();
  end
endmodule : tb_timer_capture_compare_channels
